// File: bcfs_pkg.sv
/*
 Constants for the step-up clock fault and spread control block:
 register map, field positions, reset values, timing and spread limits.
 Assumes a 50 MHz system clock and a plain byte-addressed register port.
*/
`default_nettype none
package bcfs_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 4;
   localparam int FREQ_W = 12;
   // register byte addresses
   localparam logic [ADDR_W-1:0] RAIL_CONTROL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] SAFETY_CONFIG_THREE_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] ERR_COUNT_ADDR = 8'h0C;
   localparam logic [ADDR_W-1:0] ERR_LIMIT_ADDR = 8'h10;
   localparam logic [ADDR_W-1:0] SPREAD_FREQ_ADDR = 8'h14;
   // rail control fields
   localparam int STEP_UP_ON_BIT = 0;
   localparam int RESET_COND_BIT = 1;
   localparam int CLK_MON_ON_BIT = 2;
   localparam int SYNC_MON_ON_BIT = 3;
   localparam int GO_ACTIVE_BIT = 4;
   localparam int CLK_MON_TEST_BIT = 5;
   // safety config three fields
   localparam int SPREAD_ON_BIT = 0;
   // status fields
   localparam int FAULT_BIT = 0;
   localparam int MON_TEST_FAIL_BIT = 1;
   localparam int FREQ_WARN_BIT = 2;
   localparam int STATE_LSB = 4;
   localparam int STATE_MSB = 6;
   // reset values
   localparam logic RESET_COND_RST = 1'b1;
   localparam logic CLK_MON_ON_RST = 1'b1;
   localparam logic [CNT_W-1:0] ERR_LIMIT_RST = 4'h7;
   // timing
   localparam int RESET_TIMEOUT_US = 10_000;
   localparam int HOST_STEP_SPACING_US = 50;
   localparam int HOST_STEP_LIMIT_KHZ = 100;
   localparam int SPREAD_STEP_US = 1;
   localparam int SPREAD_STEP_CYC = (SPREAD_STEP_US * (CLK_HZ / 1_000_000) > 1) ?
      SPREAD_STEP_US * (CLK_HZ / 1_000_000) : 1;
   // spread limits in kHz, frequency warning threshold in percent
   localparam logic [FREQ_W-1:0] FREQ_MIN_KHZ = 12'd1790;
   localparam logic [FREQ_W-1:0] FREQ_MAX_KHZ = 12'd2398;
   localparam logic [FREQ_W-1:0] FREQ_NOM_KHZ = 12'd2100;
   localparam int WARN_PCT = 17;
   localparam int PCT_FULL = 100;

   typedef enum logic [2:0] {
      ST_OFF, ST_RESET, ST_DIAG, ST_ACTIVE, ST_SAFE
   } bcfs_state_t;
endpackage : bcfs_pkg
`default_nettype wire

// File: bcfs_spread_lfsr.sv
/*
 Pseudo-random frequency picker for internal randomized spreading.
 Assumes a one-cycle step enable and the package spread limits.
*/
`timescale 1ns/10ps
`default_nettype none
module bcfs_spread_lfsr
   import bcfs_pkg::*;
#(
   parameter int LFSR_W = 10
) (
   input wire logic sys_clk, // system clock
   input wire logic resetn, // sync reset, active low
   input wire logic run, // spreading active
   input wire logic step, // one-cycle step enable
   output logic [FREQ_W-1:0] freqKhz // chosen frequency
);
   localparam logic [LFSR_W-1:0] SEED = 10'h1A5;
   localparam logic [FREQ_W-1:0] SPAN = FREQ_MAX_KHZ - FREQ_MIN_KHZ;
   logic [LFSR_W-1:0] lfsr_q;
   logic fb;

   assign fb = lfsr_q[LFSR_W-1] ^ lfsr_q[LFSR_W-4];

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lfsr_q <= SEED;
      end else if (step) begin
         lfsr_q <= {lfsr_q[LFSR_W-2:0], fb};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn || !run) begin
         freqKhz <= FREQ_NOM_KHZ;
      end else if (step && FREQ_W'(lfsr_q) <= SPAN) begin
         freqKhz <= FREQ_MIN_KHZ + FREQ_W'(lfsr_q);
      end
   end
endmodule : bcfs_spread_lfsr
`default_nettype wire

// File: bcfs_ctrl.sv
/*
 Fail-safe control for the step-up converter switching-clock fault,
 with the recovery sequence and switching-clock spread control.
 Assumes analog monitors on pins (synchronised here) and a host
 register port on the system clock; the frequency input is local.
*/
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module bcfs_ctrl
   import bcfs_pkg::*;
#(
   parameter int RESET_TIMEOUT_CYC = RESET_TIMEOUT_US * (CLK_HZ / 1_000_000)
) (
   input wire logic sys_clk, // system clock
   input wire logic resetn, // sync reset, active low
   input wire logic [ADDR_W-1:0] regAddr, // register byte address
   input wire logic [DATA_W-1:0] regWdata, // write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   output logic [DATA_W-1:0] regRdata, // read data, next cycle
   input wire logic clkFaultPin, // step-up clock monitor fault
   input wire logic oscGoodPin, // internal oscillator good
   input wire logic underVoltPin, // step-up below uv threshold
   input wire logic belowRestartPin, // step-up below restart level
   input wire logic selfTestDonePin, // self-test finished
   input wire logic selfTestPassPin, // self-test result
   input wire logic monTestDonePin, // clock monitor test finished
   input wire logic monTestFailPin, // clock monitor test result
   input wire logic extModeStrap, // factory: external modulation
   input wire logic [FREQ_W-1:0] measFreqKhz, // measured clock, kHz
   output logic stepUpEnable, // converter on
   output logic dischargeOn, // resistive discharge on
   output logic driveEnableIrqN, // drive-enable/irq pin, low=irq
   output logic mcuResetN, // mcu reset output, low=reset
   output logic selfTestStart, // self-test start pulse
   output logic monTestStart, // clock monitor test pulse
   output logic useSyncClock, // clocks follow sync input
   output logic spreadActive, // internal spreading running
   output logic [FREQ_W-1:0] spreadFreqKhz, // spread frequency
   output logic [2:0] stateOut // fail-safe state
);
   localparam int TMO_W = $clog2(RESET_TIMEOUT_CYC + 1);
   localparam int STEP_W = $clog2(SPREAD_STEP_CYC + 1);
   localparam int SYNC_N = 6;

   function automatic logic deviates(input logic [FREQ_W-1:0] f);
      logic [31:0] diff;
      diff = (f > FREQ_NOM_KHZ) ? 32'(f - FREQ_NOM_KHZ) : 32'(FREQ_NOM_KHZ - f);
      return (diff * PCT_FULL) >= (32'(FREQ_NOM_KHZ) * WARN_PCT);
   endfunction : deviates

   function automatic logic isOperating(input bcfs_state_t s);
      return s != ST_OFF;
   endfunction : isOperating

   // pin synchronisers
   logic [SYNC_N-1:0] pinRaw, sync1_q, sync2_q;
   logic strapSync1_q, strapSync2_q;
   logic clkFault, oscGood, underVolt, belowRestart;
   logic stDone, stPass, mtDone, mtFail;

   assign pinRaw = {clkFaultPin, oscGoodPin, underVoltPin, belowRestartPin,
                    selfTestDonePin, selfTestPassPin};

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pinRaw;
         sync2_q <= sync1_q;
      end
   end

   logic [1:0] mtSync1_q, mtSync2_q;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mtSync1_q <= '0;
         mtSync2_q <= '0;
      end else begin
         mtSync1_q <= {monTestDonePin, monTestFailPin};
         mtSync2_q <= mtSync1_q;
      end
   end

   // strap sync runs through reset, settled at release
   always_ff @(posedge sys_clk) begin
      strapSync1_q <= extModeStrap;
      strapSync2_q <= strapSync1_q;
   end

   assign {clkFault, oscGood, underVolt, belowRestart, stDone, stPass} = sync2_q;
   assign {mtDone, mtFail} = mtSync2_q;

   // factory mode caught once after reset release
   logic extMode_q, strapTaken_q;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         extMode_q <= 1'b0;
         strapTaken_q <= 1'b0;
      end else if (!strapTaken_q) begin
         extMode_q <= strapSync2_q;
         strapTaken_q <= 1'b1;
      end
   end

   bcfs_state_t state_q;
   logic clkFaultPrev_q, faultEvent;
   logic stepUpOn_q, resetCond_q, clkMonOn_q, syncMonOn_q, spreadOn_q;
   logic faultSticky_q, monFailSticky_q, freqWarn_q;
   logic [CNT_W-1:0] errCount_q, errLimit_q;
   logic [TMO_W-1:0] tmo_q;
   logic testBusy_q, monBusy_q;
   logic wrRail, wrCfg3, wrStatus, wrLimit;
   logic stFailEvent, stPassEvent;

   assign wrRail = regWr && regAddr == RAIL_CONTROL_ADDR;
   assign wrCfg3 = regWr && regAddr == SAFETY_CONFIG_THREE_ADDR;
   assign wrStatus = regWr && regAddr == STATUS_ADDR;
   assign wrLimit = regWr && regAddr == ERR_LIMIT_ADDR;

   assign faultEvent = clkFault && !clkFaultPrev_q && oscGood && clkMonOn_q
                       && isOperating(state_q);
   assign stPassEvent = testBusy_q && stDone && stPass;
   assign stFailEvent = testBusy_q && stDone && !stPass;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         clkFaultPrev_q <= 1'b0;
      end else begin
         clkFaultPrev_q <= clkFault;
      end
   end

   // fail-safe state machine
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= ST_RESET;
      end else if (faultEvent) begin
         state_q <= ST_SAFE;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               state_q <= ST_OFF;
            end
            ST_RESET: begin
               if (stFailEvent) begin
                  state_q <= ST_SAFE;
               end else if (stPassEvent) begin
                  state_q <= ST_DIAG;
               end else if (tmo_q == TMO_W'(RESET_TIMEOUT_CYC)) begin
                  state_q <= ST_OFF;
               end
            end
            ST_DIAG: begin
               if (wrRail && regWdata[GO_ACTIVE_BIT]) begin
                  state_q <= ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               state_q <= ST_ACTIVE;
            end
            ST_SAFE: begin
               if (errCount_q >= errLimit_q) begin
                  state_q <= ST_OFF;
               end else if (resetCond_q && underVolt) begin
                  state_q <= ST_RESET;
               end
            end
         endcase
      end
   end

   // reset state timeout, restarted on each entry
   always_ff @(posedge sys_clk) begin
      if (!resetn || state_q != ST_RESET) begin
         tmo_q <= '0;
      end else if (!underVolt) begin
         tmo_q <= '0;
      end else if (tmo_q != TMO_W'(RESET_TIMEOUT_CYC)) begin
         tmo_q <= tmo_q + 1'b1;
      end
   end

   // converter enable
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stepUpEnable <= 1'b0;
      end else if (faultEvent || state_q == ST_OFF) begin
         stepUpEnable <= 1'b0;
      end else if (state_q == ST_RESET && !stepUpEnable) begin
         stepUpEnable <= belowRestart && !clkFault;
      end else if (wrRail && regWdata[STEP_UP_ON_BIT]) begin
         stepUpEnable <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      dischargeOn <= 1'b0;
   end

   // self-test run with reset extension
   always_ff @(posedge sys_clk) begin
      if (!resetn || state_q != ST_RESET) begin
         testBusy_q <= 1'b0;
         selfTestStart <= 1'b0;
      end else begin
         selfTestStart <= !testBusy_q && !selfTestStart && stepUpEnable && !underVolt
                          && !faultEvent;
         if (selfTestStart) begin
            testBusy_q <= 1'b1;
         end else if (stDone) begin
            testBusy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mcuResetN <= 1'b0;
      end else begin
         mcuResetN <= state_q == ST_DIAG || state_q == ST_ACTIVE
                      || state_q == ST_SAFE;
      end
   end

   // error counter
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         errCount_q <= '0;
      end else if ((faultEvent || stFailEvent) && errCount_q != '1) begin
         errCount_q <= errCount_q + 1'b1;
      end
   end

   // host configuration bits
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         resetCond_q <= RESET_COND_RST;
         clkMonOn_q <= CLK_MON_ON_RST;
         errLimit_q <= ERR_LIMIT_RST;
      end else begin
         if (wrRail) begin
            resetCond_q <= regWdata[RESET_COND_BIT];
            clkMonOn_q <= regWdata[CLK_MON_ON_BIT];
         end
         if (wrLimit) begin
            errLimit_q <= regWdata[CNT_W-1:0];
         end
      end
   end

   // sync input monitor enable
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         syncMonOn_q <= 1'b0;
      end else if (state_q == ST_RESET) begin
         syncMonOn_q <= 1'b0;
      end else if (wrRail) begin
         syncMonOn_q <= regWdata[SYNC_MON_ON_BIT];
      end
   end

   // internal spread enable
   always_ff @(posedge sys_clk) begin
      if (!resetn || state_q == ST_OFF) begin
         spreadOn_q <= 1'b0;
      end else if (wrCfg3 && state_q == ST_DIAG && !extMode_q) begin
         spreadOn_q <= regWdata[SPREAD_ON_BIT];
      end
   end

   // clock monitor diagnostic
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         monBusy_q <= 1'b0;
         monTestStart <= 1'b0;
      end else begin
         monTestStart <= wrRail && regWdata[CLK_MON_TEST_BIT]
                         && state_q == ST_SAFE && !monBusy_q;
         if (monTestStart) begin
            monBusy_q <= 1'b1;
         end else if (mtDone) begin
            monBusy_q <= 1'b0;
         end
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         faultSticky_q <= 1'b0;
         monFailSticky_q <= 1'b0;
      end else begin
         if (faultEvent) begin
            faultSticky_q <= 1'b1;
         end else if (wrStatus && regWdata[FAULT_BIT]) begin
            faultSticky_q <= 1'b0;
         end
         if (monBusy_q && mtDone && mtFail) begin
            monFailSticky_q <= 1'b1;
         end else if (wrStatus && regWdata[MON_TEST_FAIL_BIT]) begin
            monFailSticky_q <= 1'b0;
         end
      end
   end

   // irq pin low while fault pending
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         driveEnableIrqN <= 1'b1;
      end else begin
         driveEnableIrqN <= !(faultEvent || (faultSticky_q
                            && !(wrStatus && regWdata[FAULT_BIT])));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         freqWarn_q <= 1'b0;
      end else begin
         freqWarn_q <= deviates(measFreqKhz);
      end
   end

   // sync clock only after reset release
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         useSyncClock <= 1'b0;
         spreadActive <= 1'b0;
      end else begin
         useSyncClock <= extMode_q && mcuResetN && syncMonOn_q;
         spreadActive <= !extMode_q && spreadOn_q;
      end
   end

   // spread step divider
   logic [STEP_W-1:0] stepCnt_q;
   logic stepTick;
   assign stepTick = stepCnt_q == STEP_W'(SPREAD_STEP_CYC - 1);
   always_ff @(posedge sys_clk) begin
      if (!resetn || stepTick) begin
         stepCnt_q <= '0;
      end else begin
         stepCnt_q <= stepCnt_q + 1'b1;
      end
   end

   bcfs_spread_lfsr u_lfsr (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(spreadActive),
      .step(stepTick),
      .freqKhz(spreadFreqKhz)
   );

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         stateOut <= '0;
      end else begin
         stateOut <= state_q;
      end
   end

   // register read port
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         regRdata <= '0;
      end else if (regRd) begin
         regRdata <= '0;
         unique case (regAddr)
            RAIL_CONTROL_ADDR: begin
               regRdata[STEP_UP_ON_BIT] <= stepUpEnable;
               regRdata[RESET_COND_BIT] <= resetCond_q;
               regRdata[CLK_MON_ON_BIT] <= clkMonOn_q;
               regRdata[SYNC_MON_ON_BIT] <= syncMonOn_q;
            end
            SAFETY_CONFIG_THREE_ADDR: begin
               regRdata[SPREAD_ON_BIT] <= spreadOn_q;
            end
            STATUS_ADDR: begin
               regRdata[FAULT_BIT] <= faultSticky_q;
               regRdata[MON_TEST_FAIL_BIT] <= monFailSticky_q;
               regRdata[FREQ_WARN_BIT] <= freqWarn_q;
               regRdata[STATE_MSB:STATE_LSB] <= state_q;
            end
            ERR_COUNT_ADDR: begin
               regRdata[CNT_W-1:0] <= errCount_q;
            end
            ERR_LIMIT_ADDR: begin
               regRdata[CNT_W-1:0] <= errLimit_q;
            end
            SPREAD_FREQ_ADDR: begin
               regRdata[FREQ_W-1:0] <= spreadFreqKhz;
            end
            default: begin
               regRdata <= '0;
            end
         endcase
      end else begin
         regRdata <= '0;
      end
   end
endmodule : bcfs_ctrl
`default_nettype wire

// File: bcfs_ctrl_checker.sv
/*
 Port checker for bcfs_ctrl: fault reaction, recovery states, spread.
 Assumes one clock with sync active-low reset; bound at the foot.
*/
`timescale 1ns/10ps
`default_nettype none
module bcfs_ctrl_checker
   import bcfs_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic resetn, // reset, low
   input wire logic [ADDR_W-1:0] regAddr, // address
   input wire logic [DATA_W-1:0] regWdata, // write data
   input wire logic regWr, // write strobe
   input wire logic clkFaultPin, // clock fault
   input wire logic oscGoodPin, // oscillator good
   input wire logic underVoltPin, // undervoltage
   input wire logic stepUpEnable, // converter on
   input wire logic dischargeOn, // discharge on
   input wire logic driveEnableIrqN, // irq, low
   input wire logic mcuResetN, // mcu reset, low
   input wire logic useSyncClock, // sync clock used
   input wire logic spreadActive, // spreading
   input wire logic [FREQ_W-1:0] spreadFreqKhz, // spread freq
   input wire logic [2:0] stateOut // state
);
   logic monOn_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // monitor enable as last written
   always_ff @(posedge sys_clk) begin
      if (!resetn) monOn_q <= CLK_MON_ON_RST;
      else if (regWr && regAddr == RAIL_CONTROL_ADDR) monOn_q <= regWdata[CLK_MON_ON_BIT];
   end
   sequence faultSeen;
      $rose(clkFaultPin) && oscGoodPin && monOn_q && stateOut != ST_OFF;
   endsequence
   AST_FAULT_OFF: assert property (faultSeen |-> ##[1:4] !stepUpEnable)
      else $error("converter on after fault");
   AST_NO_DISCHARGE: assert property (!dischargeOn)
      else $error("discharge turned on");
   AST_FAULT_SAFE: assert property (faultSeen and !underVoltPin |-> ##[2:6] stateOut == ST_SAFE)
      else $error("no safe state after fault");
   AST_FAULT_IRQ: assert property (faultSeen |-> ##[1:4] !driveEnableIrqN)
      else $error("irq not raised after fault");
   AST_IRQ_HOLD: assert property (!driveEnableIrqN && !(regWr && regAddr == STATUS_ADDR
      && regWdata[FAULT_BIT]) |=> !driveEnableIrqN)
      else $error("irq released without clear");
   AST_RESET_HOLD: assert property (stateOut == ST_RESET |-> !mcuResetN)
      else $error("mcu reset released in reset state");
   AST_SYNC_GATE: assert property ($rose(useSyncClock) |-> mcuResetN)
      else $error("sync clock used during mcu reset");
   AST_SYNC_DROP: assert property ($rose(stateOut == ST_RESET) |-> ##[1:3] !useSyncClock)
      else $error("sync clock kept in reset state");
   AST_SPREAD_RANGE: assert property (spreadActive |->
      spreadFreqKhz >= FREQ_MIN_KHZ && spreadFreqKhz <= FREQ_MAX_KHZ)
      else $error("spread frequency out of range");
   AST_SPREAD_START: assert property ($rose(spreadActive) |-> stateOut == ST_DIAG)
      else $error("spread started outside diagnostic");
   AST_SPREAD_STOP: assert property ($fell(spreadActive) |->
      ##[0:1] (stateOut == ST_DIAG || stateOut == ST_OFF))
      else $error("spread stopped in wrong state");
endmodule : bcfs_ctrl_checker
bind bcfs_ctrl bcfs_ctrl_checker chkr (.sys_clk, .resetn, .regAddr, .regWdata, .regWr,
   .clkFaultPin, .oscGoodPin, .underVoltPin, .stepUpEnable, .dischargeOn, .driveEnableIrqN,
   .mcuResetN, .useSyncClock, .spreadActive, .spreadFreqKhz, .stateOut);
`default_nettype wire

// File: bcfs_plant_model.sv
/*
 Analog side model: step-up output level, self-test and monitor test.
 Assumes the controller outputs on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module bcfs_plant_model (
   input wire logic sys_clk, // clock
   input wire logic stepUpEnable, // converter on
   input wire logic selfTestStart, // self-test pulse
   input wire logic monTestStart, // monitor test pulse
   input wire logic stFail, // self-test fails
   input wire logic stuck, // output cannot rise
   output logic underVoltPin, // below uv
   output logic belowRestartPin, // below restart
   output logic selfTestDonePin, // self-test done
   output logic selfTestPassPin, // self-test result
   output logic monTestDonePin, // monitor test done
   output logic monTestFailPin // monitor test result
);
   logic [6:0] lvl = 7'h00;
   logic [4:0] stCnt = 5'h00;
   logic [4:0] mtCnt = 5'h00;
   // rises when on and not stuck, decays when off or stuck
   always_ff @(posedge sys_clk) begin
      if (stepUpEnable && !stuck && lvl < 7'h64) lvl <= lvl + 7'h01;
      else if ((!stepUpEnable || stuck) && lvl > 7'h00) lvl <= lvl - 7'h01;
   end
   assign underVoltPin = (lvl < 7'h50);
   assign belowRestartPin = (lvl < 7'h14);
   always_ff @(posedge sys_clk) begin
      if (selfTestStart) stCnt <= 5'h10;
      else if (stCnt != 5'h00) stCnt <= stCnt - 5'h01;
   end
   assign selfTestDonePin = (stCnt != 5'h00 && stCnt < 5'h05);
   assign selfTestPassPin = !stFail;
   always_ff @(posedge sys_clk) begin
      if (monTestStart) mtCnt <= 5'h10;
      else if (mtCnt != 5'h00) mtCnt <= mtCnt - 5'h01;
   end
   assign monTestDonePin = (mtCnt != 5'h00 && mtCnt < 5'h05);
   assign monTestFailPin = 1'b1;
endmodule : bcfs_plant_model
`default_nettype wire

// File: tb_bcfs_ctrl.sv
/*
 Self-checking bench for bcfs_ctrl with the analog plant model.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_bcfs_ctrl
   import bcfs_pkg::*;
();
   logic sys_clk, resetn, regWr, regRd, clkFaultPin, oscGoodPin, extModeStrap, stFail, stuck;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWdata, regRdata;
   logic [FREQ_W-1:0] measFreqKhz, spreadFreqKhz;
   logic underVoltPin, belowRestartPin, selfTestDonePin, selfTestPassPin, monTestDonePin;
   logic monTestFailPin, stepUpEnable, dischargeOn, driveEnableIrqN, mcuResetN;
   logic selfTestStart, monTestStart, useSyncClock, spreadActive;
   logic [2:0] stateOut;
   int mismatches = 0;
   int num_checks = 0;
   bcfs_ctrl #(.RESET_TIMEOUT_CYC(200)) DUT (.sys_clk, .resetn, .regAddr, .regWdata, .regWr,
      .regRd, .regRdata, .clkFaultPin, .oscGoodPin, .underVoltPin, .belowRestartPin,
      .selfTestDonePin, .selfTestPassPin, .monTestDonePin, .monTestFailPin, .extModeStrap,
      .measFreqKhz, .stepUpEnable, .dischargeOn, .driveEnableIrqN, .mcuResetN, .selfTestStart,
      .monTestStart, .useSyncClock, .spreadActive, .spreadFreqKhz, .stateOut);
   bcfs_plant_model plant (.sys_clk, .stepUpEnable, .selfTestStart, .monTestStart, .stFail,
      .stuck, .underVoltPin, .belowRestartPin, .selfTestDonePin, .selfTestPassPin,
      .monTestDonePin, .monTestFailPin);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      tick(1);
      regWr <= 1'b0;
      tick(1);
   endtask : wr
   // read, mask, compare
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      tick(1);
      regRd <= 1'b0;
      chk(regRdata & m, e);
      tick(1);
   endtask : rc
   task automatic waitSt(input logic [2:0] s);
      int n;
      n = 0;
      while (stateOut !== s && n < 3000) begin
         tick(1);
         n++;
      end
      chk({29'h0, stateOut}, {29'h0, s});
   endtask : waitSt
   task automatic fault;
      clkFaultPin <= 1'b1;
      tick(8);
      clkFaultPin <= 1'b0;
   endtask : fault
   task automatic doReset(input logic strap);
      extModeStrap <= strap;
      resetn <= 1'b0;
      tick(16);
      resetn <= 1'b1;
      tick(1);
   endtask : doReset
   initial begin
      #400000;
      mismatches++;
      end_sim();
   end
   initial begin
      {resetn, regWr, regRd, clkFaultPin, extModeStrap, stFail, stuck} = 7'h00;
      oscGoodPin = 1'b1;
      regAddr = 8'h00;
      regWdata = 32'h0;
      measFreqKhz = 12'd2100;
      // internal spread mode, power-up recovery
      doReset(1'b0);
      waitSt(ST_DIAG);
      chk1(mcuResetN, 1'b1);
      rc(RAIL_CONTROL_ADDR, 32'hE, 32'h6);
      rc(ERR_LIMIT_ADDR, 32'hF, 32'h7);
      rc(8'h18, 32'hFFFFFFFF, 32'h0);
      measFreqKhz <= 12'd1743;
      tick(4);
      rc(STATUS_ADDR, 32'h4, 32'h4);
      measFreqKhz <= 12'd1744;
      tick(4);
      rc(STATUS_ADDR, 32'h4, 32'h0);
      measFreqKhz <= 12'd2100;
      wr(SAFETY_CONFIG_THREE_ADDR, 32'h1);
      tick(3);
      chk1(spreadActive, 1'b1);
      tick(120);
      chk1(spreadFreqKhz >= FREQ_MIN_KHZ && spreadFreqKhz <= FREQ_MAX_KHZ, 1'b1);
      wr(ERR_LIMIT_ADDR, 32'h3);
      wr(RAIL_CONTROL_ADDR, 32'h16);
      waitSt(ST_ACTIVE);
      stFail <= 1'b1;
      fault();
      waitSt(ST_SAFE);
      chk1(driveEnableIrqN, 1'b0);
      chk1(stepUpEnable, 1'b0);
      rc(STATUS_ADDR, 32'h71, 32'h41);
      rc(ERR_COUNT_ADDR, 32'hF, 32'h1);
      waitSt(ST_RESET);
      chk1(spreadActive, 1'b1);
      waitSt(ST_SAFE);
      rc(ERR_COUNT_ADDR, 32'hF, 32'h2);
      fault();
      waitSt(ST_OFF);
      rc(ERR_COUNT_ADDR, 32'hF, 32'h3);
      tick(2);
      chk1(spreadActive, 1'b0);
      // external mode, no reset condition
      stFail <= 1'b0;
      doReset(1'b1);
      waitSt(ST_DIAG);
      wr(SAFETY_CONFIG_THREE_ADDR, 32'h1);
      tick(3);
      chk1(spreadActive, 1'b0);
      // sync input never stepped by host
      wr(RAIL_CONTROL_ADDR, 32'h0E);
      tick(3);
      chk1(useSyncClock, 1'b1);
      wr(RAIL_CONTROL_ADDR, 32'h1C);
      waitSt(ST_ACTIVE);
      fault();
      waitSt(ST_SAFE);
      tick(150);
      chk({29'h0, stateOut}, {29'h0, ST_SAFE});
      wr(STATUS_ADDR, 32'h1);
      tick(2);
      chk1(driveEnableIrqN, 1'b1);
      wr(RAIL_CONTROL_ADDR, 32'h2C);
      tick(40);
      rc(STATUS_ADDR, 32'h2, 32'h2);
      // monitoring dropped, converter on by host
      wr(RAIL_CONTROL_ADDR, 32'h09);
      tick(3);
      chk1(stepUpEnable, 1'b1);
      fault();
      tick(4);
      chk1(stepUpEnable, 1'b1);
      chk1(driveEnableIrqN, 1'b1);
      rc(ERR_COUNT_ADDR, 32'hF, 32'h1);
      stuck <= 1'b1;
      wr(RAIL_CONTROL_ADDR, 32'h0E);
      waitSt(ST_RESET);
      tick(3);
      chk1(useSyncClock, 1'b0);
      rc(RAIL_CONTROL_ADDR, 32'h8, 32'h0);
      waitSt(ST_OFF);
      end_sim();
   end
endmodule : tb_bcfs_ctrl
`default_nettype wire
